/* File: design/pmux_pkg.sv */
// Constants and register map for the port alternate-function pin multiplexer
package pmux_pkg;

  // Pin group widths and register address width
  localparam int LOW_W  = 16;
  localparam int UP_W   = 6;
  localparam int P41_W  = 5;
  localparam int EDGE_W = 3;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_LOW_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LOW_DIR  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LOW_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_UP_DATA  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_UP_DIR   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_UP_MODE  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_P41_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EDGE_EN  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h20;

  // Port4 pin1 control field positions
  localparam int P41_DATA_BIT = 0;
  localparam int P41_DIR_BIT  = 1;
  localparam int P41_MODE_BIT = 2;
  localparam int P41_SEL_BIT  = 3;
  localparam int P41_OD_BIT   = 4;

  // Edge enable and status field positions
  localparam int RISE_LSB        = 0;
  localparam int FALL_LSB        = 4;
  localparam int STATUS_FLASH    = 0;
  localparam int FLASH_PIN       = 5;

  // Reset values: every pin in port input mode
  localparam logic [LOW_W-1:0] RST_LOW_DIR   = 16'hFFFF;
  localparam logic [UP_W-1:0]  RST_UP_DIR    = 6'h3F;
  localparam logic [LOW_W-1:0] RST_LOW_ZERO  = 16'h0000;
  localparam logic [UP_W-1:0]  RST_UP_ZERO   = 6'h00;
  localparam logic [P41_W-1:0] RST_P41       = 5'h02;
  localparam logic [EDGE_W-1:0] RST_EDGE     = 3'h0;

  // AHB-Lite encodings
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

/* File: design/pmux_group.sv */
// Registered output stage for a group of shared port pins
`timescale 1ns/1ps
module pmux_group #(
  parameter int W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] mode,
  input  wire logic [W-1:0] od,
  input  wire logic [W-1:0] alt_out,
  input  wire logic [W-1:0] alt_oe,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe_n,
  output logic      [W-1:0] alt_in
);

  typedef struct packed {
    logic [W-1:0] pin_out;
    logic [W-1:0] pin_oe_n;
    logic [W-1:0] alt_in;
  } pmux_grp_state_t;

  pmux_grp_state_t s;
  pmux_grp_state_t next_s;

  // Per-pin choice between port latch and alternate function
  always_comb begin
    logic [W-1:0] val;
    logic [W-1:0] drv;
    val = (mode & alt_out) | (~mode & latch);
    drv = (mode & alt_oe) | (~mode & ~dir);
    // Open-drain releases a high; port inputs never drive anyway
    drv = drv & ~(od & val);
    next_s.pin_out  = val & ~od;
    next_s.pin_oe_n = ~drv;
    next_s.alt_in   = mode & pin_in;
  end

  // Pins follow the selection one cycle after it is written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{pin_out: '0, pin_oe_n: '1, alt_in: '0};
    end else begin
      s <= next_s;
    end
  end

  assign pin_out  = s.pin_out;
  assign pin_oe_n = s.pin_oe_n;
  assign alt_in   = s.alt_in;

endmodule

/* File: design/pmux_p41.sv */
// Port4 pin1 stage: port, serial data output or open-drain two-wire clock
`timescale 1ns/1ps
module pmux_p41 (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic latch,
  input  wire logic dir,
  input  wire logic mode,
  input  wire logic sel,
  input  wire logic od,
  input  wire logic sout,
  input  wire logic sclk_out,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      sclk_in
);

  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
    logic sclk_in;
  } pmux_p41_state_t;

  pmux_p41_state_t s;
  pmux_p41_state_t next_s;

  // Select bit only matters once the mode bit is set
  always_comb begin
    logic val;
    logic drv;
    val = mode ? (sel ? sclk_out : sout) : latch;
    drv = mode | ~dir;
    // This pin has a real N-channel open-drain option
    drv = drv & ~(od & val);
    next_s.pin_out  = val & ~od;
    next_s.pin_oe_n = ~drv;
    next_s.sclk_in  = mode & sel & pin_in;
  end

  // Reset leaves the pin released, as a port input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{pin_out: 1'b0, pin_oe_n: 1'b1, sclk_in: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign pin_out  = s.pin_out;
  assign pin_oe_n = s.pin_oe_n;
  assign sclk_in  = s.sclk_in;

endmodule

/* File: design/pmux_top.sv */
// Port alternate-function multiplexer with its AHB-Lite register slave
`timescale 1ns/1ps
module pmux_top (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic      [31:0]                   hrdata,
  output logic                               hresp,
  // Flash programming mode
  input  wire logic                          flash_prog_mode,
  output logic                               flash_mode_input,
  // Upper address pins
  input  wire logic [pmux_pkg::UP_W-1:0]     upper_address_line,
  input  wire logic [pmux_pkg::UP_W-1:0]     upper_addr_port_pin_in,
  output logic      [pmux_pkg::UP_W-1:0]     upper_addr_port_pin_out,
  output logic      [pmux_pkg::UP_W-1:0]     upper_addr_port_pin_oe_n,
  // Lower data pins and the muxed address/data bus
  input  wire logic [pmux_pkg::LOW_W-1:0]    muxed_addr_data_line_out,
  input  wire logic                          muxed_addr_data_line_oe,
  output logic      [pmux_pkg::LOW_W-1:0]    muxed_addr_data_line_in,
  input  wire logic [pmux_pkg::LOW_W-1:0]    lower_data_port_pin_in,
  output logic      [pmux_pkg::LOW_W-1:0]    lower_data_port_pin_out,
  output logic      [pmux_pkg::LOW_W-1:0]    lower_data_port_pin_oe_n,
  // Port4 pin1 and its two peripheral functions
  input  wire logic                          serial_data_out_zero,
  input  wire logic                          two_wire_clock_line_out,
  output logic                               two_wire_clock_line_in,
  input  wire logic                          port4_pin1_in,
  output logic                               port4_pin1_out,
  output logic                               port4_pin1_oe_n,
  // Port9 high edge-detect enables
  output logic      [pmux_pkg::EDGE_W-1:0]   rising_edge_enable_port9_high,
  output logic      [pmux_pkg::EDGE_W-1:0]   falling_edge_enable_port9_high
);

  import pmux_pkg::*;

  typedef struct packed {
    logic [LOW_W-1:0]  low_latch;
    logic [LOW_W-1:0]  low_dir;
    logic [LOW_W-1:0]  low_mode;
    logic [UP_W-1:0]   up_latch;
    logic [UP_W-1:0]   up_dir;
    logic [UP_W-1:0]   up_mode;
    logic [P41_W-1:0]  p41;
    logic [EDGE_W-1:0] rise_en;
    logic [EDGE_W-1:0] fall_en;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       rdata;
    logic              ready;
    logic              resp;
    logic              flash_in;
  } pmux_top_state_t;

  pmux_top_state_t s;
  pmux_top_state_t next_s;

  // Data register view: latch for output pins, pin level for inputs
  function automatic logic [31:0] port_read(input logic [LOW_W-1:0] latch,
                                            input logic [LOW_W-1:0] dir,
                                            input logic [LOW_W-1:0] pin);
    logic [LOW_W-1:0] v;
    v = (latch & ~dir) | (pin & dir);
    return {16'h0000, v};
  endfunction

  // Widens an upper-group vector to the low-group width
  function automatic logic [LOW_W-1:0] up_ext(input logic [UP_W-1:0] v);
    return {10'h000, v};
  endfunction

  // Register read decode; unmapped offsets read as zero
  function automatic logic [31:0] reg_read(input pmux_top_state_t st,
                                           input logic [ADDR_W-1:0] a,
                                           input logic [LOW_W-1:0] low_pin,
                                           input logic [UP_W-1:0] up_pin,
                                           input logic p41_pin,
                                           input logic fmode);
    logic [31:0] r;
    logic [31:0] p;
    r = RDATA_ZERO;
    p = RDATA_ZERO;
    case (a)
      OFF_LOW_DATA: begin
        r = port_read(st.low_latch, st.low_dir, low_pin);
      end
      OFF_LOW_DIR: begin
        r = {16'h0000, st.low_dir};
      end
      OFF_LOW_MODE: begin
        r = {16'h0000, st.low_mode};
      end
      OFF_UP_DATA: begin
        r = port_read(up_ext(st.up_latch), up_ext(st.up_dir), up_ext(up_pin));
      end
      OFF_UP_DIR: begin
        r = {26'h000_0000, st.up_dir};
      end
      OFF_UP_MODE: begin
        r = {26'h000_0000, st.up_mode};
      end
      OFF_P41_CTRL: begin
        p = port_read({15'h0000, st.p41[P41_DATA_BIT]},
                      {15'h0000, st.p41[P41_DIR_BIT]},
                      {15'h0000, p41_pin});
        r = {27'h000_0000, st.p41};
        r[P41_DATA_BIT] = p[0];
      end
      OFF_EDGE_EN: begin
        r[RISE_LSB +: EDGE_W] = st.rise_en;
        r[FALL_LSB +: EDGE_W] = st.fall_en;
      end
      OFF_STATUS: begin
        r[STATUS_FLASH] = fmode;
      end
      default: begin
        r = RDATA_ZERO;
      end
    endcase
    return r;
  endfunction

  // Bus slave and register update
  always_comb begin
    logic take;
    logic mapped;
    take   = hsel & hready & htrans[1];
    mapped = (haddr[31:ADDR_W] == 24'h00_0000) && (haddr[1:0] == 2'b00);
    next_s = s;
    // Zero wait states, always OKAY
    next_s.ready = 1'b1;
    next_s.resp  = 1'b0;
    // Flash-mode input ignores every port control register
    next_s.flash_in = flash_prog_mode & lower_data_port_pin_in[FLASH_PIN];
    // Address phase: note a write, or fetch read data now
    next_s.wr_pend = take & hwrite & mapped & (hsize == HSIZE_WORD);
    next_s.wr_addr = haddr[ADDR_W-1:0];
    if (take && !hwrite) begin
      next_s.rdata = mapped ? reg_read(s, haddr[ADDR_W-1:0], lower_data_port_pin_in,
                                       upper_addr_port_pin_in, port4_pin1_in,
                                       flash_prog_mode) : RDATA_ZERO;
    end
    // Data phase: write lands at the end of this cycle
    if (s.wr_pend) begin
      case (s.wr_addr)
        OFF_LOW_DATA: begin
          next_s.low_latch = hwdata[LOW_W-1:0];
        end
        OFF_LOW_DIR: begin
          next_s.low_dir = hwdata[LOW_W-1:0];
        end
        OFF_LOW_MODE: begin
          next_s.low_mode = hwdata[LOW_W-1:0];
        end
        OFF_UP_DATA: begin
          next_s.up_latch = hwdata[UP_W-1:0];
        end
        OFF_UP_DIR: begin
          next_s.up_dir = hwdata[UP_W-1:0];
        end
        OFF_UP_MODE: begin
          next_s.up_mode = hwdata[UP_W-1:0];
        end
        OFF_P41_CTRL: begin
          // Any order accepted; a bad order shows briefly on the pin
          next_s.p41 = hwdata[P41_W-1:0];
        end
        OFF_EDGE_EN: begin
          next_s.rise_en = hwdata[RISE_LSB +: EDGE_W];
          next_s.fall_en = hwdata[FALL_LSB +: EDGE_W];
        end
        default: begin
          next_s.wr_pend = 1'b0;
        end
      endcase
    end
  end

  // All selection state moves on the clock edge of the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{low_latch: RST_LOW_ZERO, low_dir: RST_LOW_DIR, low_mode: RST_LOW_ZERO,
             up_latch: RST_UP_ZERO, up_dir: RST_UP_DIR, up_mode: RST_UP_ZERO,
             p41: RST_P41, rise_en: RST_EDGE, fall_en: RST_EDGE,
             wr_pend: 1'b0, wr_addr: '0, rdata: RDATA_ZERO,
             ready: 1'b1, resp: 1'b0, flash_in: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // Upper address pins: always outputs in alternate mode
  pmux_group #(
    .W (UP_W)
  ) u_upper (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .latch    (s.up_latch),
    .dir      (s.up_dir),
    .mode     (s.up_mode),
    .od       ({UP_W{1'b0}}),
    .alt_out  (upper_address_line),
    .alt_oe   ({UP_W{1'b1}}),
    .pin_in   (upper_addr_port_pin_in),
    .pin_out  (upper_addr_port_pin_out),
    .pin_oe_n (upper_addr_port_pin_oe_n),
    .alt_in   ()
  );

  // Lower data pins: bus controller steers the direction
  pmux_group #(
    .W (LOW_W)
  ) u_lower (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .latch    (s.low_latch),
    .dir      (s.low_dir),
    .mode     (s.low_mode),
    .od       ({LOW_W{1'b0}}),
    .alt_out  (muxed_addr_data_line_out),
    .alt_oe   ({LOW_W{muxed_addr_data_line_oe}}),
    .pin_in   (lower_data_port_pin_in),
    .pin_out  (lower_data_port_pin_out),
    .pin_oe_n (lower_data_port_pin_oe_n),
    .alt_in   (muxed_addr_data_line_in)
  );

  // Port4 pin1 with its open-drain option
  pmux_p41 u_p41 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .latch    (s.p41[P41_DATA_BIT]),
    .dir      (s.p41[P41_DIR_BIT]),
    .mode     (s.p41[P41_MODE_BIT]),
    .sel      (s.p41[P41_SEL_BIT]),
    .od       (s.p41[P41_OD_BIT]),
    .sout     (serial_data_out_zero),
    .sclk_out (two_wire_clock_line_out),
    .pin_in   (port4_pin1_in),
    .pin_out  (port4_pin1_out),
    .pin_oe_n (port4_pin1_oe_n),
    .sclk_in  (two_wire_clock_line_in)
  );

  // Outputs straight from state flops
  assign hreadyout                      = s.ready;
  assign hrdata                         = s.rdata;
  assign hresp                          = s.resp;
  assign flash_mode_input               = s.flash_in;
  assign rising_edge_enable_port9_high  = s.rise_en;
  assign falling_edge_enable_port9_high = s.fall_en;

endmodule

/* File: dv/pmux_props.sv */
// Assertion checker for the port pin multiplexer, bound to its top module
`timescale 1ns/1ps
module pmux_props
  import pmux_pkg::*;
(
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic             flash_prog_mode,
  input wire logic             flash_mode_input,
  input wire logic [UP_W-1:0]  upper_address_line,
  input wire logic [UP_W-1:0]  upper_addr_port_pin_out,
  input wire logic [UP_W-1:0]  upper_addr_port_pin_oe_n,
  input wire logic [LOW_W-1:0] lower_data_port_pin_in,
  input wire logic [LOW_W-1:0] muxed_addr_data_line_in,
  input wire logic             serial_data_out_zero,
  input wire logic             two_wire_clock_line_out,
  input wire logic             two_wire_clock_line_in,
  input wire logic             port4_pin1_in,
  input wire logic             port4_pin1_out,
  input wire logic             port4_pin1_oe_n
);
  logic             ap_w;
  logic [31:0]      ap_a;
  logic [UP_W-1:0]  um;
  logic [P41_W-1:0] pc;
  logic             p_ser, p_clkod, p_in, fl, tw;

  // Shadow of upper mode and port4 pin1 control; a write lands in its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_w <= 1'b0;
      ap_a <= 32'h0000_0000;
      um   <= RST_UP_ZERO;
      pc   <= RST_P41;
    end else begin
      if (ap_w && ap_a == {24'h00_0000, OFF_UP_MODE}) um <= hwdata[UP_W-1:0];
      if (ap_w && ap_a == {24'h00_0000, OFF_P41_CTRL}) pc <= hwdata[P41_W-1:0];
      if (hready) begin
        ap_w <= hsel && htrans[1] && hwrite && hsize == HSIZE_WORD;
        ap_a <= haddr;
      end
    end
  end

  // Decoded selections and alternate-input sources
  assign p_ser   = pc[2] & ~pc[3] & ~pc[4];
  assign p_clkod = pc[2] & pc[3] & pc[4];
  assign p_in    = ~pc[2] & pc[1];
  assign fl      = flash_prog_mode & lower_data_port_pin_in[FLASH_PIN];
  assign tw      = pc[2] & pc[3] & port4_pin1_in;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Pin outputs are registered, so each pin relation looks one edge back
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_upper_addr: assert property ($past(hresetn) |->
    ((upper_addr_port_pin_out ^ $past(upper_address_line)) & $past(um)) == 6'h00)
    else $error("upper pin does not carry the address line");
  a_upper_drive: assert property ($past(hresetn) |->
    (upper_addr_port_pin_oe_n & $past(um)) == 6'h00)
    else $error("upper pin released in alternate mode");
  a_flash_pin: assert property ($past(hresetn) |-> flash_mode_input == $past(fl))
    else $error("flash mode input wrong");
  a_ad_masked: assert property ($past(hresetn) |->
    (muxed_addr_data_line_in & ~$past(lower_data_port_pin_in)) == 16'h0000)
    else $error("address/data input high on a low pin");
  a_p41_serial: assert property (p_ser |=>
    !port4_pin1_oe_n && port4_pin1_out == $past(serial_data_out_zero))
    else $error("serial data not on port4 pin1");
  a_p41_clk_od: assert property (p_clkod |=>
    port4_pin1_oe_n == $past(two_wire_clock_line_out) && !port4_pin1_out)
    else $error("two-wire clock not open-drain");
  a_p41_input: assert property (p_in |=> port4_pin1_oe_n)
    else $error("port4 pin1 driven in input mode");
  a_twclk_in: assert property ($past(hresetn) |-> two_wire_clock_line_in == $past(tw))
    else $error("two-wire clock input not gated by mode");
endmodule

bind pmux_top pmux_props u_props (.*);

/* File: dv/port_alternate_function_mux_tb.sv */
// Randomised self-checking bench for the port pin multiplexer
`timescale 1ns/1ps
module port_alternate_function_mux_tb;
  import pmux_pkg::*;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              flash_prog_mode, flash_mode_input, muxed_addr_data_line_oe;
  logic              serial_data_out_zero, two_wire_clock_line_out, two_wire_clock_line_in;
  logic              port4_pin1_in, port4_pin1_out, port4_pin1_oe_n;
  logic [UP_W-1:0]   upper_address_line, upper_addr_port_pin_in;
  logic [UP_W-1:0]   upper_addr_port_pin_out, upper_addr_port_pin_oe_n;
  logic [LOW_W-1:0]  muxed_addr_data_line_out, muxed_addr_data_line_in;
  logic [LOW_W-1:0]  lower_data_port_pin_in, lower_data_port_pin_out, lower_data_port_pin_oe_n;
  logic [EDGE_W-1:0] rising_edge_enable_port9_high, falling_edge_enable_port9_high;
  // Bench copy of the registers, and pin levels seen when a read is taken
  logic [LOW_W-1:0]  l_dat, l_dir, l_mode, cl;
  logic [UP_W-1:0]   u_dat, u_dir, u_mode, cu;
  logic [P41_W-1:0]  p41;
  logic [6:0]        edg;
  logic              cp, cf;
  logic [63:0]       rnd;
  integer            seed = 32'h0541_007f;
  int                bad_count = 0;
  int                num_checks = 0;
  logic [31:0]       tab [12] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0008,
    32'h0000_000c, 32'h0000_0010, 32'h0000_0014, 32'h0000_0018, 32'h0000_001c,
    32'h0000_0020, 32'h0000_0024, 32'h0000_0002, 32'h0000_0104};
  logic [4:0]        pseq [8] = '{5'h06, 5'h0e, 5'h1e, 5'h02, 5'h12, 5'h1a, 5'h1e, 5'h11};

  pmux_top u_dut (.hready(hreadyout), .*);

  // Free-running 200 MHz clock
  always #2.5 hclk = ~hclk;

  // Fresh random pin levels and peripheral outputs from time zero, then every cycle
  always begin
    rnd = {$random(seed), $random(seed)};
    {upper_address_line, upper_addr_port_pin_in, muxed_addr_data_line_out,
      muxed_addr_data_line_oe, lower_data_port_pin_in, serial_data_out_zero,
      two_wire_clock_line_out, port4_pin1_in, flash_prog_mode} <= rnd[48:0];
    @(posedge hclk);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read value: output latch where the pin is an output, pin level where it is an input
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    if (a[31:8] != 24'h00_0000) return 32'h0000_0000;
    case (a[7:0])
      OFF_LOW_DATA: return {16'h0000, l_dat & ~l_dir | cl & l_dir};
      OFF_LOW_DIR:  return {16'h0000, l_dir};
      OFF_LOW_MODE: return {16'h0000, l_mode};
      OFF_UP_DATA:  return {26'h000_0000, u_dat & ~u_dir | cu & u_dir};
      OFF_UP_DIR:   return {26'h000_0000, u_dir};
      OFF_UP_MODE:  return {26'h000_0000, u_mode};
      OFF_P41_CTRL: return {27'h000_0000, p41[4:1], p41[1] ? cp : p41[0]};
      OFF_EDGE_EN:  return {25'h000_0000, edg};
      OFF_STATUS:   return {31'h0000_0000, cf};
      default:      return 32'h0000_0000;
    endcase
  endfunction

  // One single AHB-Lite transfer; zero-wait slave, but the wait is on hready anyway
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {cl, cu, cp, cf} = {lower_data_port_pin_in, upper_addr_port_pin_in, port4_pin1_in,
      flash_prog_mode};
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) chk(hrdata, exp_rd(a));
    else if (a[31:8] == 24'h00_0000)
      case (a[7:0])
        OFF_LOW_DATA: l_dat = d[15:0];
        OFF_LOW_DIR:  l_dir = d[15:0];
        OFF_LOW_MODE: l_mode = d[15:0];
        OFF_UP_DATA:  u_dat = d[5:0];
        OFF_UP_DIR:   u_dir = d[5:0];
        OFF_UP_MODE:  u_mode = d[5:0];
        OFF_P41_CTRL: p41 = d[4:0];
        OFF_EDGE_EN:  edg = d[6:0] & 7'h77;
        default:      ;
      endcase
  endtask

  // Compare every pin output with the previous cycle's inputs and the bench registers;
  // both are looked at mid-cycle so that no edge race decides what is seen
  task automatic pins(input int n);
    logic [LOW_W-1:0] pa, pm, oel;
    logic [UP_W-1:0]  pu, oeu;
    logic             po, ps, pk, pp, pf, v, drv;
    @(negedge hclk);
    {pa, pm, pu, po, ps, pk, pp} = {lower_data_port_pin_in, muxed_addr_data_line_out,
      upper_address_line, muxed_addr_data_line_oe, serial_data_out_zero,
      two_wire_clock_line_out, port4_pin1_in};
    pf = flash_prog_mode & pa[FLASH_PIN];
    repeat (n) begin
      @(negedge hclk);
      oeu = ~u_mode & u_dir;
      oel = l_mode & {LOW_W{~po}} | ~l_mode & l_dir;
      v = p41[2] ? (p41[3] ? pk : ps) : p41[0];
      drv = p41[2] | ~p41[1];
      chk(upper_addr_port_pin_oe_n, oeu);
      chk(upper_addr_port_pin_out & ~oeu, (u_mode & pu | ~u_mode & u_dat) & ~oeu);
      chk(lower_data_port_pin_oe_n, oel);
      chk(lower_data_port_pin_out & ~oel, (l_mode & pm | ~l_mode & l_dat) & ~oel);
      chk(muxed_addr_data_line_in, l_mode & pa);
      chk(flash_mode_input, pf);
      chk({port4_pin1_oe_n, port4_pin1_out & drv}, {~drv | p41[4] & v, drv & ~p41[4] & v});
      chk(two_wire_clock_line_in, p41[2] & p41[3] & pp);
      chk({rising_edge_enable_port9_high, falling_edge_enable_port9_high},
        {edg[2:0], edg[6:4]});
      {pa, pm, pu, po, ps, pk, pp} = {lower_data_port_pin_in, muxed_addr_data_line_out,
        upper_address_line, muxed_addr_data_line_oe, serial_data_out_zero,
        two_wire_clock_line_out, port4_pin1_in};
      pf = flash_prog_mode & pa[FLASH_PIN];
    end
    // Hand back just after a rising edge, where bus requests may start
    @(posedge hclk);
  endtask

  task automatic rst;
    hresetn <= 1'b0;
    {l_dat, l_dir, l_mode} = {16'h0000, RST_LOW_DIR, 16'h0000};
    {u_dat, u_dir, u_mode} = {6'h00, RST_UP_DIR, 6'h00};
    p41 = RST_P41;
    edg = 7'h00;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic results;
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Two rounds, the second after a reset in mid-run
  initial begin
    hclk = 1'b0;
    hsize = HSIZE_WORD;
    {hsel, haddr, htrans, hwrite, hwdata} = 68'h0;
    for (int r = 0; r < 2; r++) begin
      rst();
      pins(2);  // released pins after reset
      foreach (tab[i]) bus(tab[i], 1'b0, 32'h0000_0000);
      foreach (pseq[i]) begin
        bus(tab[6], 1'b1, {27'h000_0000, pseq[i]});
        pins(2);
      end
      bus(tab[2], 1'b1, 32'h0000_ffff);
      bus(tab[5], 1'b1, 32'h0000_003f);
      pins(8);
      repeat (40) begin
        bus(tab[$unsigned($random(seed)) % 12], 1'b1, $random(seed));
        pins(2);
        bus(tab[$unsigned($random(seed)) % 12], 1'b0, 32'h0000_0000);
      end
      bus(tab[7], 1'b1, 32'h0000_00ff);
      pins(2);
      bus(tab[7], 1'b1, 32'h0000_0000);  // all edge enables cleared
      pins(2);
    end
    results();
  end

  // Cuts a hung handshake short; the sequence needs well under this span
  initial begin
    #100_000;
    bad_count++;
    results();
  end
endmodule
